// ### design/gpio_params.svh
// register offsets, field positions and reset values of the gpio block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// per-port registers: port 0 at the offset, port 1 at offset + 4
`define OFS_DIR 12'h000
`define OFS_MASK 12'h008
`define OFS_PIN 12'h010
`define OFS_MPIN 12'h018
`define OFS_SET 12'h020
`define OFS_CLR 12'h028
`define OFS_NOT 12'h030
// group regs: word index = group * 2 + port
`define OFS_GRPPOL 12'h040
`define OFS_GRPENA 12'h050
`define OFS_GRPCTRL 12'h060
`define OFS_GRPSTAT 12'h064
// pin interrupt and pattern engine
`define OFS_INTSEL_LO 12'h080
`define OFS_INTSEL_HI 12'h084
`define OFS_ISEL 12'h088
`define OFS_IENR 12'h08C
`define OFS_IENF 12'h090
`define OFS_RISE 12'h094
`define OFS_FALL 12'h098
`define OFS_PMCTRL 12'h09C
`define OFS_PMSRC 12'h0A0
`define OFS_PMCFG 12'h0A4
`define OFS_PMEND 12'h0A8

`define PMCTRL_MODE 0
`define PMCTRL_EVENT 1
`define PMCTRL_PIN 2
`define RST_WORD 32'h0000_0000

`endif

// ### design/gpio_pkg.sv
// types shared by the gpio block
`default_nettype none
package gpio_pkg;
    typedef enum logic [2:0] {
        SL_ALWAYS = 3'b000,
        SL_STICKY_RISE = 3'b001,
        SL_STICKY_FALL = 3'b010,
        SL_STICKY_BOTH = 3'b011,
        SL_HIGH = 3'b100,
        SL_LOW = 3'b101,
        SL_NEVER = 3'b110,
        SL_EDGE = 3'b111
    } slice_cfg_e;
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_DEEP = 2'b10,
        PWR_DOWN = 2'b11
    } power_e;
endpackage
`default_nettype wire

// ### design/gpio_pin_irq_pattern_match.sv
// two 32-bit gpio ports with group, pin and pattern-match interrupts
//
// What this block does
// [R1] two ports, 64 pins in all
// [R2] each pin has its own direction bit
// [R3] after reset all direction bits are zero, every pin an input
// [R4] set and clear writes drive ones-written bits high or low
// [R5] toggle write inverts every output bit written as one
// [R6] pin read returns the pad level whatever function owns it
// [R7] masked access leaves masked-off output bits unchanged
// [R8] byte and half-word writes update only the addressed lanes
// [R9] one word write sets all bits of a port's output
// [R10] two group interrupts each match their own pin combination
// [R11] group interrupts request wake-up from sleep, deep-sleep, power-down
// [R12] eight selectable pins each drive their own interrupt line
// [R13] pin selection ignores which function owns the pin
// [R14] edge interrupts fire on rising, falling or both edges
// [R15] level interrupts are active high or low and track the pin
// [R16] pin interrupts request wake-up from sleep and deep-sleep
// [R17] pattern engine ands levels or transitions of eight selected pins
// [R18] each product term drives its own interrupt line
// [R19] a match can pulse a cpu event, routable to a pin
// [R20] pattern engine wakes only from the sleep state
// [R21] pin inputs are synchronised before detection
`include "gpio_params.svh"
`default_nettype none
module gpio_pin_irq_pattern_match
    import gpio_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] pinIn,
    output logic [63:0] pinOut,
    output logic [63:0] pinOe,
    input wire logic [1:0] powerState,
    output logic [7:0] pinIrq,
    output logic [1:0] grpIrq,
    output logic cpuEventNotify,
    output logic cpuEventPin,
    output logic wakeRequest
);

////////////////////////////////////////////////////////////////////////////
// apb decode

logic pready_r, pslverr_r;
logic [31:0] prdata_r, rdNxt;
logic errNxt;
logic [63:0] dir_r, msk_r, out_r, dirNxt, mskNxt, outNxt;
logic [63:0] sync1_r, sync2_r, sync3_r, pinLvl_r, pinPrev_r;
logic [127:0] grpPol_r, grpEna_r, grpPolNxt, grpEnaNxt;
logic [1:0] grpCtrl_r, grpIrq_r, grpNxt;
logic [63:0] intSel_r, intSelNxt;
logic [7:0] isel_r, ienr_r, ienf_r, rise_r, fall_r, riseNxt, fallNxt;
logic [2:0] pmCtrl_r;
logic [23:0] pmSrc_r, pmCfg_r;
logic [7:0] pmEnd_r, stick_r, stickNxt, termPrev_r, pinIrq_r;
logic [7:0] selNow, selPrev, term, pintOut, irqNxt;
logic event_r, eventPin_r, wake_r, eventNxt, wakeNxt;

wire [11:0] addr = {paddr[11:2], 2'b00};
wire [11:0] base = {paddr[11:3], 3'b000};
wire port = paddr[2];
wire setupAcc = psel & penable & ~pready_r;
wire accept = psel & penable & pready_r;
wire doWr = accept & pwrite;
wire [31:0] wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
    {8{pstrb[0]}}};
wire [11:0] polBase = `OFS_GRPPOL;
wire [11:0] enaBase = `OFS_GRPENA;
wire hitDir = base == `OFS_DIR;
wire hitMask = base == `OFS_MASK;
wire hitPin = base == `OFS_PIN;
wire hitMpin = base == `OFS_MPIN;
wire hitSet = base == `OFS_SET;
wire hitClr = base == `OFS_CLR;
wire hitNot = base == `OFS_NOT;
wire hitPol = paddr[11:4] == polBase[11:4];
wire hitEna = paddr[11:4] == enaBase[11:4];
wire [6:0] grpWord = {paddr[3:2], 5'b00000};
wire hitGctl = addr == `OFS_GRPCTRL;
wire hitGst = addr == `OFS_GRPSTAT;
wire hitSelLo = addr == `OFS_INTSEL_LO;
wire hitSelHi = addr == `OFS_INTSEL_HI;
wire hitIsel = addr == `OFS_ISEL;
wire hitIenr = addr == `OFS_IENR;
wire hitIenf = addr == `OFS_IENF;
wire hitRise = addr == `OFS_RISE;
wire hitFall = addr == `OFS_FALL;
wire hitPmc = addr == `OFS_PMCTRL;
wire hitPms = addr == `OFS_PMSRC;
wire hitPmf = addr == `OFS_PMCFG;
wire hitPme = addr == `OFS_PMEND;
wire [31:0] wbits = pwdata & wm;
wire pmMode = pmCtrl_r[`PMCTRL_MODE];

function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [31:0] en);
    merge = (old & ~en) | (dat & en);
endfunction

// read data is captured in the first access cycle, one wait state
always_comb begin
    rdNxt = `RST_WORD;
    errNxt = 1'b0;
    if (hitDir) begin
        rdNxt = dir_r[32*port +: 32];
    end else if (hitMask) begin
        rdNxt = msk_r[32*port +: 32];
    end else if (hitPin) begin
        // [R6] pad level readback
        rdNxt = pinLvl_r[32*port +: 32];
    end else if (hitMpin) begin
        rdNxt = pinLvl_r[32*port +: 32] & ~msk_r[32*port +: 32];
    end else if (hitSet || hitClr || hitNot) begin
        rdNxt = out_r[32*port +: 32];
    end else if (hitPol) begin
        rdNxt = grpPol_r[grpWord +: 32];
    end else if (hitEna) begin
        rdNxt = grpEna_r[grpWord +: 32];
    end else if (hitGctl) begin
        rdNxt = {30'h0000_0000, grpCtrl_r};
    end else if (hitGst) begin
        rdNxt = {30'h0000_0000, grpIrq_r};
    end else if (hitSelLo) begin
        rdNxt = intSel_r[31:0];
    end else if (hitSelHi) begin
        rdNxt = intSel_r[63:32];
    end else if (hitIsel) begin
        rdNxt = {24'h00_0000, isel_r};
    end else if (hitIenr) begin
        rdNxt = {24'h00_0000, ienr_r};
    end else if (hitIenf) begin
        rdNxt = {24'h00_0000, ienf_r};
    end else if (hitRise) begin
        rdNxt = {24'h00_0000, rise_r};
    end else if (hitFall) begin
        rdNxt = {24'h00_0000, fall_r};
    end else if (hitPmc) begin
        rdNxt = {29'h0000_0000, pmCtrl_r};
    end else if (hitPms) begin
        rdNxt = {8'h00, pmSrc_r};
    end else if (hitPmf) begin
        rdNxt = {8'h00, pmCfg_r};
    end else if (hitPme) begin
        rdNxt = {16'h0000, term, pmEnd_r};
    end else begin
        errNxt = 1'b1;
    end
end

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= `RST_WORD;
    end else begin
        pready_r <= setupAcc;
        pslverr_r <= setupAcc & errNxt;
        prdata_r <= setupAcc ? rdNxt : `RST_WORD;
    end
end

////////////////////////////////////////////////////////////////////////////
// port registers

always_comb begin
    dirNxt = dir_r;
    mskNxt = msk_r;
    outNxt = out_r;
    for (int p = 0; p < 2; p++) begin
        if (doWr && port == p[0]) begin
            // [R2] per-bit direction, [R8] lane-gated via wm
            if (hitDir) begin
                dirNxt[32*p +: 32] = merge(dir_r[32*p +: 32], pwdata, wm);
            end else if (hitMask) begin
                mskNxt[32*p +: 32] = merge(msk_r[32*p +: 32], pwdata, wm);
            // [R9] whole port write
            end else if (hitPin) begin
                outNxt[32*p +: 32] = merge(out_r[32*p +: 32], pwdata, wm);
            // [R7] masked-off bits keep their value
            end else if (hitMpin) begin
                outNxt[32*p +: 32] = merge(out_r[32*p +: 32], pwdata,
                    wm & ~msk_r[32*p +: 32]);
            // [R4] set and clear
            end else if (hitSet) begin
                outNxt[32*p +: 32] = out_r[32*p +: 32] | wbits;
            end else if (hitClr) begin
                outNxt[32*p +: 32] = out_r[32*p +: 32] & ~wbits;
            // [R5] toggle
            end else if (hitNot) begin
                outNxt[32*p +: 32] = out_r[32*p +: 32] ^ wbits;
            end
        end
    end
end

// [R1] [R3] 64 pins, all inputs after reset
always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        dir_r <= 64'h0000_0000_0000_0000;
        msk_r <= 64'h0000_0000_0000_0000;
        out_r <= 64'h0000_0000_0000_0000;
    end else begin
        dir_r <= dirNxt;
        msk_r <= mskNxt;
        out_r <= outNxt;
    end
end

////////////////////////////////////////////////////////////////////////////
// pin synchroniser

// [R21] three stages, a change counts once stages two and three agree
wire [63:0] agree = ~(sync2_r ^ sync3_r);
wire [63:0] lvlNxt = (agree & sync3_r) | (~agree & pinLvl_r);

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        sync1_r <= 64'h0000_0000_0000_0000;
        sync2_r <= 64'h0000_0000_0000_0000;
        sync3_r <= 64'h0000_0000_0000_0000;
        pinLvl_r <= 64'h0000_0000_0000_0000;
        pinPrev_r <= 64'h0000_0000_0000_0000;
    end else begin
        sync1_r <= pinIn;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        pinLvl_r <= lvlNxt;
        pinPrev_r <= pinLvl_r;
    end
end

////////////////////////////////////////////////////////////////////////////
// group interrupts

// [R10] or-mode: any enabled pin active; and-mode: all enabled active
always_comb begin
    for (int g = 0; g < 2; g++) begin
        logic [63:0] ena;
        logic [63:0] act;
        ena = grpEna_r[64*g +: 64];
        act = ena & ~(pinLvl_r ^ grpPol_r[64*g +: 64]);
        grpNxt[g] = grpCtrl_r[g] ? ((|ena) && act == ena) : (|act);
    end
end

always_comb begin
    grpPolNxt = grpPol_r;
    grpEnaNxt = grpEna_r;
    if (doWr && hitPol) begin
        grpPolNxt[grpWord +: 32] = merge(grpPol_r[grpWord +: 32], pwdata, wm);
    end
    if (doWr && hitEna) begin
        grpEnaNxt[grpWord +: 32] = merge(grpEna_r[grpWord +: 32], pwdata, wm);
    end
end

////////////////////////////////////////////////////////////////////////////
// pin interrupts

// [R12] [R13] any pin, taken from the pad level not the owning function
always_comb begin
    for (int k = 0; k < 8; k++) begin
        selNow[k] = pinLvl_r[intSel_r[8*k +: 6]];
        selPrev[k] = pinPrev_r[intSel_r[8*k +: 6]];
    end
end

wire [7:0] riseEv = selNow & ~selPrev;
wire [7:0] fallEv = ~selNow & selPrev;
wire [7:0] clrRise = (doWr && hitRise) ? wbits[7:0] : 8'h00;
wire [7:0] clrFall = (doWr && hitFall) ? wbits[7:0] : 8'h00;

// sticky edge flags, a new edge beats a clear in the same cycle
assign riseNxt = (rise_r & ~clrRise) | (riseEv & ~isel_r);
assign fallNxt = (fall_r & ~clrFall) | (fallEv & ~isel_r);
// [R14] edge mode, [R15] level mode with ienf as active level
assign pintOut = (isel_r & ienr_r & ~(selNow ^ ienf_r)) |
    (~isel_r & ((rise_r & ienr_r) | (fall_r & ienf_r)));

////////////////////////////////////////////////////////////////////////////
// pattern engine

wire clrStick = doWr && (hitPms || hitPmf);
logic [7:0] sliceHit;

// [R17] slices chained into product terms ended by pmEnd bits
always_comb begin
    logic acc;
    logic sL, sP;
    slice_cfg_e cfg;
    acc = 1'b1;
    sL = 1'b0;
    sP = 1'b0;
    cfg = SL_ALWAYS;
    stickNxt = clrStick ? 8'h00 : stick_r;
    for (int k = 0; k < 8; k++) begin
        sL = selNow[pmSrc_r[3*k +: 3]];
        sP = selPrev[pmSrc_r[3*k +: 3]];
        cfg = slice_cfg_e'(pmCfg_r[3*k +: 3]);
        case (cfg)
            SL_STICKY_RISE: stickNxt[k] = stickNxt[k] | (sL & ~sP);
            SL_STICKY_FALL: stickNxt[k] = stickNxt[k] | (~sL & sP);
            SL_STICKY_BOTH: stickNxt[k] = stickNxt[k] | (sL ^ sP);
            default: stickNxt[k] = stickNxt[k];
        endcase
        case (cfg)
            SL_ALWAYS: sliceHit[k] = 1'b1;
            SL_STICKY_RISE, SL_STICKY_FALL,
            SL_STICKY_BOTH: sliceHit[k] = stick_r[k];
            SL_HIGH: sliceHit[k] = sL;
            SL_LOW: sliceHit[k] = ~sL;
            SL_NEVER: sliceHit[k] = 1'b0;
            default: sliceHit[k] = sL ^ sP;
        endcase
        acc = acc & sliceHit[k];
        // [R18] a term ends at each end slice; slice 7 always ends one
        term[k] = acc & (pmEnd_r[k] | (k == 7));
        if (pmEnd_r[k]) begin
            acc = 1'b1;
        end
    end
end

// [R19] one pulse when any term newly matches
assign eventNxt = pmMode & pmCtrl_r[`PMCTRL_EVENT] & (|(term & ~termPrev_r));
assign irqNxt = pmMode ? term : pintOut;

// [R11] [R16] [R20] wake request by power state
assign wakeNxt =
    ((|grpNxt) && powerState != PWR_ACTIVE) ||
    (!pmMode && (|pintOut) &&
        (powerState == PWR_SLEEP || powerState == PWR_DEEP)) ||
    (pmMode && (|term) && powerState == PWR_SLEEP);

always_comb begin
    intSelNxt = intSel_r;
    if (doWr && hitSelLo) begin
        intSelNxt[31:0] = merge(intSel_r[31:0], pwdata, wm);
    end
    if (doWr && hitSelHi) begin
        intSelNxt[63:32] = merge(intSel_r[63:32], pwdata, wm);
    end
end

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        grpPol_r <= {4{`RST_WORD}};
        grpEna_r <= {4{`RST_WORD}};
        grpCtrl_r <= 2'b00;
        grpIrq_r <= 2'b00;
        intSel_r <= {2{`RST_WORD}};
        isel_r <= 8'h00;
        ienr_r <= 8'h00;
        ienf_r <= 8'h00;
        rise_r <= 8'h00;
        fall_r <= 8'h00;
        pmCtrl_r <= 3'b000;
        pmSrc_r <= 24'h00_0000;
        pmCfg_r <= 24'h00_0000;
        pmEnd_r <= 8'h00;
        stick_r <= 8'h00;
        termPrev_r <= 8'h00;
        pinIrq_r <= 8'h00;
        event_r <= 1'b0;
        eventPin_r <= 1'b0;
        wake_r <= 1'b0;
    end else begin
        grpPol_r <= grpPolNxt;
        grpEna_r <= grpEnaNxt;
        if (doWr && hitGctl) grpCtrl_r <= 2'(merge({30'h0, grpCtrl_r},
            pwdata, wm));
        grpIrq_r <= grpNxt;
        intSel_r <= intSelNxt;
        if (doWr && hitIsel) isel_r <= 8'(merge({24'h0, isel_r},
            pwdata, wm));
        if (doWr && hitIenr) ienr_r <= 8'(merge({24'h0, ienr_r},
            pwdata, wm));
        if (doWr && hitIenf) ienf_r <= 8'(merge({24'h0, ienf_r},
            pwdata, wm));
        rise_r <= riseNxt;
        fall_r <= fallNxt;
        if (doWr && hitPmc) pmCtrl_r <= 3'(merge({29'h0, pmCtrl_r},
            pwdata, wm));
        if (doWr && hitPms) pmSrc_r <= 24'(merge({8'h0, pmSrc_r},
            pwdata, wm));
        if (doWr && hitPmf) pmCfg_r <= 24'(merge({8'h0, pmCfg_r},
            pwdata, wm));
        if (doWr && hitPme) pmEnd_r <= 8'(merge({24'h0, pmEnd_r},
            pwdata, wm));
        stick_r <= stickNxt;
        termPrev_r <= term;
        pinIrq_r <= irqNxt;
        event_r <= eventNxt;
        eventPin_r <= eventNxt & pmCtrl_r[`PMCTRL_PIN];
        wake_r <= wakeNxt;
    end
end

assign prdata = prdata_r;
assign pready = pready_r;
assign pslverr = pslverr_r;
assign pinOut = out_r;
assign pinOe = dir_r;
assign pinIrq = pinIrq_r;
assign grpIrq = grpIrq_r;
assign cpuEventNotify = event_r;
assign cpuEventPin = eventPin_r;
assign wakeRequest = wake_r;

////////////////////////////////////////////////////////////////////////////
// checks

chk_dir_reset: assert property ( // [R3]
    @(posedge clock) $past(resetn) == 1'b0 && resetn |-> pinOe == 64'h0)
    else $error("pins not inputs after reset");
chk_set_bits: assert property ( // [R4]
    @(posedge clock) disable iff (!resetn)
    doWr && hitSet && !port && pstrb == 4'hF |=>
    pinOut[31:0] == ($past(pinOut[31:0]) | $past(pwdata)))
    else $error("set write wrong");
chk_clr_bits: assert property ( // [R4]
    @(posedge clock) disable iff (!resetn)
    doWr && hitClr && !port && pstrb == 4'hF |=>
    pinOut[31:0] == ($past(pinOut[31:0]) & ~$past(pwdata)))
    else $error("clear write wrong");
chk_toggle_bits: assert property ( // [R5]
    @(posedge clock) disable iff (!resetn)
    doWr && hitNot && !port && pstrb == 4'hF |=>
    pinOut[31:0] == ($past(pinOut[31:0]) ^ $past(pwdata)))
    else $error("toggle write wrong");
chk_mask_keep: assert property ( // [R7]
    @(posedge clock) disable iff (!resetn)
    doWr && hitMpin && !port |=>
    (pinOut[31:0] & $past(msk_r[31:0])) ==
    ($past(pinOut[31:0]) & $past(msk_r[31:0])))
    else $error("masked bit changed");
chk_byte_lane: assert property ( // [R8]
    @(posedge clock) disable iff (!resetn)
    doWr && hitPin && !port && pstrb == 4'h1 |=>
    pinOut[31:8] == $past(pinOut[31:8]))
    else $error("unaddressed lane changed");
chk_pad_read: assert property ( // [R6]
    @(posedge clock) disable iff (!resetn)
    setupAcc && !pwrite && hitPin && !port |=>
    pready && prdata == $past(pinLvl_r[31:0]))
    else $error("pad readback wrong");
chk_sync_agree: assert property ( // [R21]
    @(posedge clock) disable iff (!resetn)
    ((pinLvl_r ^ $past(pinLvl_r)) & $past(sync2_r ^ sync3_r)) == 64'h0)
    else $error("level taken before stages agree");
chk_level_irq: assert property ( // [R15]
    @(posedge clock) disable iff (!resetn)
    !pmMode && isel_r[0] && ienr_r[0] && selNow[0] == ienf_r[0] |=>
    pinIrq[0])
    else $error("level interrupt missing");
chk_event_pulse: assert property ( // [R19]
    @(posedge clock) disable iff (!resetn)
    cpuEventNotify |=> !cpuEventNotify)
    else $error("event longer than one cycle");

endmodule
`default_nettype wire

// ### tb/pin_pad_model.sv
// pad model: each pin shows its driven output or the external level
`default_nettype none
module pin_pad_model (
    input wire logic [63:0] pinOut,
    input wire logic [63:0] pinOe,
    input wire logic [63:0] extLevel,
    output logic [63:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // pad level seen back
    // an output pin reads its own drive, so readback needs no loop wire
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule
`default_nettype wire

// ### tb/gpio_pin_irq_pattern_match_tb.sv
// self-checking bench of the gpio block with pin and pattern interrupts
`include "gpio_params.svh"
`default_nettype none
module gpio_pin_irq_pattern_match_tb
    import gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] P37 = 64'h0000_0020_0000_0000;
    typedef struct packed {logic rd; logic [31:0] data; logic err;} note_s;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, outV, lm;
    logic [3:0] pstrb, s;
    logic [63:0] pinIn, pinOut, pinOe, extLevel;
    logic [1:0] powerState, grpIrq;
    logic [7:0] pinIrq;
    logic cpuEventNotify, cpuEventPin, wakeRequest;
    power_e pwr;
    note_s notes [$];
    note_s cur;
    int mismatches = 0;
    int checked = 0;
    int evCount = 0;
    int ev0;

    gpio_pin_irq_pattern_match i_gpio_pin_irq_pattern_match (
        .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .powerState(powerState), .pinIrq(pinIrq), .grpIrq(grpIrq),
        .cpuEventNotify(cpuEventNotify), .cpuEventPin(cpuEventPin),
        .wakeRequest(wakeRequest)
    );
    pin_pad_model i_pin_pad_model (
        .pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic step;
        repeat (8) rnd = lfsr(rnd);
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [3:0] st,
            input logic [31:0] e, input logic err);
        notes.push_back('{!wr, e, err});
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF, e, 1'b0);
    endtask
    // pads and power change, then the four-edge sync plus irq flops settle
    task automatic drive(input logic [63:0] v);
        @(posedge clock);
        extLevel <= v;
        powerState <= pwr;
        repeat (8) @(posedge clock);
    endtask
    task automatic summarize;
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                cmp(64'h1, 64'h0);
            end else begin
                cur = notes.pop_front();
                cmp(64'(pslverr), 64'(cur.err));
                if (cur.rd) begin
                    cmp(64'(prdata), 64'(cur.data));
                end
            end
        end
    end
    always @(posedge clock) begin
        if (cpuEventNotify === 1'b1 && cpuEventPin === 1'b1) begin
            evCount <= evCount + 1;
        end
    end
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        summarize;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        extLevel = 64'h0;
        pwr = PWR_ACTIVE;
        powerState = PWR_ACTIVE;
        rnd = 32'h34;
        repeat (16) @(posedge clock);
        cmp(pinOe, 64'h0);
        resetn <= 1'b1;
        rd(`OFS_DIR, 32'h0);
        rd(`OFS_DIR + 12'h4, 32'h0);
        wr(`OFS_DIR, 32'hFFFF_FFFF);
        step;
        outV = rnd;
        wr(`OFS_PIN, outV);
        drive(extLevel);
        cmp(pinOe, {32'h0, 32'hFFFF_FFFF});
        cmp(pinOut, {32'h0, outV});
        rd(`OFS_PIN, outV);
        for (int k = 0; k < 3; k++) begin
            step;
            wr(`OFS_SET + 12'(8 * k), rnd);
            outV = k == 0 ? outV | rnd : k == 1 ? outV & ~rnd : outV ^ rnd;
            rd(`OFS_NOT, outV);
        end
        for (int k = 0; k < 2; k++) begin
            step;
            s = k == 0 ? 4'b0001 : 4'b0011;
            lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
            apb(1'b1, `OFS_PIN, rnd, s, 32'h0, 1'b0);
            outV = (outV & ~lm) | (rnd & lm);
            rd(`OFS_NOT, outV);
        end
        wr(`OFS_MASK, 32'h0000_FFFF);
        step;
        wr(`OFS_MPIN, rnd);
        outV = {rnd[31:16], outV[15:0]};
        rd(`OFS_NOT, outV);
        rd(`OFS_MPIN, {outV[31:16], 16'h0});
        step;
        drive({rnd, 32'h0});
        rd(`OFS_PIN + 12'h4, rnd);
        // slot 0 on pin 37, slot 1 on output pin 3
        drive(64'h0);
        wr(`OFS_INTSEL_LO, 32'h0000_0325);
        wr(`OFS_ISEL, 32'h0);
        wr(`OFS_IENR, 32'h1);
        wr(`OFS_IENF, 32'h0);
        wr(`OFS_RISE, 32'hFF);
        wr(`OFS_FALL, 32'hFF);
        drive(P37);
        cmp(64'(pinIrq), 64'h1);
        wr(`OFS_RISE, 32'h1);
        drive(P37);
        cmp(64'(pinIrq), 64'h0);
        wr(`OFS_IENR, 32'h0);
        wr(`OFS_IENF, 32'h1);
        drive(64'h0);
        cmp(64'(pinIrq), 64'h1);
        wr(`OFS_IENR, 32'h1);
        wr(`OFS_FALL, 32'h1);
        drive(64'h0);
        cmp(64'(pinIrq), 64'h0);
        drive(P37);
        cmp(64'(pinIrq), 64'h1);
        wr(`OFS_RISE, 32'h1);
        drive(64'h0);
        cmp(64'(pinIrq), 64'h1);
        wr(`OFS_ISEL, 32'h3);
        wr(`OFS_IENR, 32'h3);
        wr(`OFS_IENF, {30'h0, outV[3], 1'b1});
        drive(64'h0);
        cmp(64'(pinIrq), 64'h2);
        drive(P37);
        cmp(64'(pinIrq), 64'h3);
        wr(`OFS_IENF, {30'h0, outV[3], 1'b0});
        drive(64'h0);
        cmp(64'(pinIrq), 64'h3);
        pwr = PWR_DEEP;
        drive(64'h0);
        cmp(64'(wakeRequest), 64'h1);
        pwr = PWR_DOWN;
        drive(64'h0);
        cmp(64'(wakeRequest), 64'h0);
        // group 0 any of pin 38, group 1 pins 38 and 39
        wr(`OFS_GRPPOL + 12'h4, 32'hC0);
        wr(`OFS_GRPPOL + 12'hC, 32'hC0);
        wr(`OFS_GRPENA + 12'h4, 32'h40);
        wr(`OFS_GRPENA + 12'hC, 32'hC0);
        wr(`OFS_GRPCTRL, 32'h2);
        drive(64'h0000_0040_0000_0000);
        cmp(64'(grpIrq), 64'h1);
        drive(64'h0000_00C0_0000_0000);
        cmp(64'(grpIrq), 64'h3);
        cmp(64'(wakeRequest), 64'h1);
        rd(`OFS_GRPSTAT, 32'h3);
        // term 0 is pin 37 high, other slices never
        pwr = PWR_ACTIVE;
        drive(64'h0);
        wr(`OFS_PMSRC, 32'h0);
        wr(`OFS_PMCFG, 32'h00DB_6DB4);
        wr(`OFS_PMEND, 32'h1);
        wr(`OFS_PMCTRL, 32'h7);
        ev0 = evCount;
        drive(P37);
        cmp(64'(pinIrq), 64'h1);
        cmp(64'(evCount - ev0), 64'h1);
        rd(`OFS_PMEND, 32'h0000_0101);
        // pattern wakes from sleep, not deep-sleep
        pwr = PWR_DEEP;
        drive(P37);
        cmp(64'(wakeRequest), 64'h0);
        pwr = PWR_SLEEP;
        drive(P37);
        cmp(64'(wakeRequest), 64'h1);
        // sticky rise chained with an always slice into term 1
        pwr = PWR_ACTIVE;
        wr(`OFS_PMEND, 32'h2);
        wr(`OFS_PMCFG, 32'h00DB_6D81);
        drive(P37);
        cmp(64'(pinIrq), 64'h0);
        drive(64'h0);
        drive(P37);
        cmp(64'(pinIrq), 64'h2);
        cmp(64'(evCount - ev0), 64'h2);
        // unmapped place answers with an error and zero data
        apb(1'b0, 12'hFF0, 32'h0, 4'hF, 32'h0, 1'b1);
        repeat (2) @(posedge clock);
        cmp(64'(notes.size()), 64'h0);
        summarize;
    end
endmodule
`default_nettype wire
